// ===== watch_timer_pkg.sv
package watch_timer_pkg;
  // register word indices (the byte address is the index shifted left by two)
  localparam logic [7:0] IDX_COUNT_INTERVAL = 8'h89;
  localparam logic [7:0] IDX_CONTROL = 8'h96;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_COUNT_INTERVAL = {IDX_COUNT_INTERVAL, 2'b00};
  localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // control fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_FLAG_BIT = 4;
  localparam int CTL_INTERVAL_LSB = 2;
  localparam int CTL_SOURCE_LSB = 0;
  localparam int INTV_CLEAR_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [6:0] INTERVAL_RESET = 7'h7F;
  // counter widths
  localparam int PRESCALE_W = 14;
  localparam int UPPER_W = 7;
  // system clock dividers for the source select
  localparam int DIV_256 = 256;
  localparam int DIV_128 = 128;
  localparam int DIV_64 = 64;
  localparam int SYSDIV_W = 8;
  // prescaler taps
  localparam int TAP_7 = 6;
  localparam int TAP_13 = 12;
  localparam int TAP_14 = 13;
  // display clock tap of the prescaler
  localparam int DISPLAY_TAP = 4;
  // pin input sync depth
  localparam int SYNC_DEPTH = 3;

  typedef enum logic [1:0] {
    SRC_SUB,
    SRC_DIV256,
    SRC_DIV128,
    SRC_DIV64
  } source_t;

  typedef enum logic [1:0] {
    INT_DIV7,
    INT_DIV13,
    INT_DIV14,
    INT_PROG
  } interval_t;

  typedef struct packed {
    logic enable;
    logic flag;
    interval_t interval_sel;
    source_t source_sel;
  } control_t;
endpackage

// ===== pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import watch_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);
  logic [SYNC_DEPTH-1:0] stage;
  wire agree = stage[1] == stage[2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage <= '0;
      level_o <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], pin_i};
      if (agree)
        level_o <= stage[2];
      rise_o <= agree && stage[2] && !level_o;
    end
  end
endmodule
`default_nettype wire

// ===== watch_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
module watch_interval_timer
  import watch_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic sub_clk_i,
  input wire logic stop_mode_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  output logic irq_o,
  output logic display_clk_o,
  output logic [6:0] upper_count_o
);
  control_t ctl;
  logic [6:0] interval_value;
  logic clear_pending;
  logic [PRESCALE_W-1:0] prescale;
  logic [UPPER_W-1:0] upper;
  logic [SYSDIV_W-1:0] sysdiv;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [PRESCALE_W-1:0] prescale_d;
  logic [UPPER_W-1:0] upper_d;
  logic sub_level;
  logic sub_rise;
  logic tick;

  pin_sync u_sub_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(sub_clk_i),
    .level_o(sub_level),
    .rise_o(sub_rise)
  );

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit_cnt = wb_adr_i == ADDR_COUNT_INTERVAL;
  wire hit_ctl = wb_adr_i == ADDR_CONTROL;
  wire hit_sts = wb_adr_i == ADDR_IRQ_STATUS;
  wire hit_msk = wb_adr_i == ADDR_IRQ_MASK;
  wire mapped = hit_cnt || hit_ctl || hit_sts || hit_msk;
  wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
  wire wr_cnt = wr_lane0 && hit_cnt;
  wire wr_ctl = wr_lane0 && hit_ctl;
  wire wr_msk = wr_lane0 && hit_msk;
  wire rd_sts = req && !wb_we_i && hit_sts;

  // watch clock source
  wire sys_tick_256 = sysdiv == SYSDIV_W'(DIV_256 - 1);
  wire sys_tick_128 = sysdiv[6:0] == 7'(DIV_128 - 1);
  wire sys_tick_64 = sysdiv[5:0] == 6'(DIV_64 - 1);
  wire sub_tick = sub_rise && sub_level;
  // sub clock passes in stop mode; system divider is frozen there
  wire sys_ok = !stop_mode_i;
  wire src_tick =
    (ctl.source_sel == SRC_SUB) ? sub_tick :
    (ctl.source_sel == SRC_DIV256) ? (sys_ok && sys_tick_256) :
    (ctl.source_sel == SRC_DIV128) ? (sys_ok && sys_tick_128) :
    (sys_ok && sys_tick_64);
  wire run = ctl.enable && !clear_pending;
  wire count_tick = run && src_tick;

  // interval end detection on the 21-bit counter
  wire pre_wrap = prescale == {PRESCALE_W{1'b1}};
  wire hit7 = prescale[TAP_7:0] == {(TAP_7 + 1){1'b1}};
  wire hit13 = prescale[TAP_13:0] == {(TAP_13 + 1){1'b1}};
  wire hit14 = prescale[TAP_14:0] == {(TAP_14 + 1){1'b1}};
  wire upper_match = upper == interval_value;
  wire prog_end = pre_wrap && upper_match;
  wire interval_end =
    (ctl.interval_sel == INT_DIV7) ? hit7 :
    (ctl.interval_sel == INT_DIV13) ? hit13 :
    (ctl.interval_sel == INT_DIV14) ? hit14 :
    prog_end;

  always_comb
  begin
    prescale_d = prescale;
    upper_d = upper;
    if (!ctl.enable || clear_pending)
    begin
      prescale_d = '0;
      upper_d = '0;
    end
    else if (count_tick)
    begin
      prescale_d = PRESCALE_W'(prescale + 1'b1);
      if (pre_wrap)
        upper_d = upper_match ? '0 : UPPER_W'(upper + 1'b1);
    end
  end

  assign tick = count_tick && interval_end;

  // flag: hardware set wins over clear by write or acknowledge
  wire flag_clr = (wr_ctl && !wb_dat_i[CTL_FLAG_BIT]) || irq_ack_i;
  wire next_flag = tick ? 1'b1 : (flag_clr ? 1'b0 : ctl.flag);
  wire [1:0] sts_set = {1'b0, tick};
  wire [1:0] next_irq_status = sts_set | (rd_sts ? 2'b00 : irq_status);

  wire [7:0] ctl_byte = {ctl.enable, 2'b00, ctl.flag,
    ctl.interval_sel, ctl.source_sel};
  wire [7:0] rd_byte =
    hit_cnt ? {1'b0, upper} :
    hit_ctl ? ctl_byte :
    hit_sts ? {6'h00, irq_status} :
    hit_msk ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sysdiv <= '0;
      prescale <= '0;
      upper <= '0;
    end
    else
    begin
      sysdiv <= sys_ok ? SYSDIV_W'(sysdiv + 1'b1) : sysdiv;
      prescale <= prescale_d;
      upper <= upper_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl <= control_t'({CONTROL_RESET[CTL_ENABLE_BIT],
        CONTROL_RESET[CTL_FLAG_BIT], CONTROL_RESET[3:0]});
      interval_value <= INTERVAL_RESET;
      clear_pending <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        ctl.enable <= wb_dat_i[CTL_ENABLE_BIT];
        ctl.interval_sel <= interval_t'(wb_dat_i[CTL_INTERVAL_LSB +: 2]);
        ctl.source_sel <= source_t'(wb_dat_i[CTL_SOURCE_LSB +: 2]);
      end
      ctl.flag <= next_flag;
      if (wr_cnt)
        interval_value <= wb_dat_i[6:0];
      clear_pending <= wr_cnt && wb_dat_i[INTV_CLEAR_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
      irq_o <= 1'b0;
      irq_req_o <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_msk)
        irq_mask <= wb_dat_i[1:0];
      irq_o <= |(next_irq_status & (wr_msk ? wb_dat_i[1:0] : irq_mask));
      irq_req_o <= tick;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
      display_clk_o <= 1'b0;
      upper_count_o <= '0;
    end
    else
    begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
      display_clk_o <= ctl.enable && prescale_d[DISPLAY_TAP];
      upper_count_o <= upper_d;
    end
  end
endmodule
`default_nettype wire

// ===== watch_timer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module watch_timer_assertions
  import watch_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic irq_req_o,
  input wire logic [6:0] upper_count_o
);
  logic req;
  logic hit;
  logic rd;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = wb_adr_i == ADDR_COUNT_INTERVAL || wb_adr_i == ADDR_CONTROL
    || wb_adr_i == ADDR_IRQ_STATUS || wb_adr_i == ADDR_IRQ_MASK;
  assign rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (req && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  chk_err_unmapped: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  chk_count_msb: assert property (
    rd && wb_adr_i == ADDR_COUNT_INTERVAL |-> !wb_dat_o[7])
    else $error("count readback bit 7 set");
  chk_ctl_unused: assert property (
    rd && wb_adr_i == ADDR_CONTROL |-> wb_dat_o[6:5] == 2'b00)
    else $error("unused control bits read nonzero");
  chk_req_single: assert property (irq_req_o |=> !irq_req_o [*8])
    else $error("interrupt request too long");
  chk_upper_step: assert property ($changed(upper_count_o) |->
    upper_count_o == $past(upper_count_o) + 7'h01 || upper_count_o == 7'h00)
    else $error("upper counter jumped");
endmodule
bind watch_interval_timer watch_timer_assertions i_watch_timer_assertions (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .irq_req_o, .upper_count_o);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import watch_timer_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, sub_clk_i = 1'b0, stop_mode_i = 1'b0;
  logic irq_ack_i = 1'b0, wb_ack_o, wb_err_o, irq_req_o, irq_o;
  logic display_clk_o, e;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [6:0] upper_count_o;
  logic [7:0] rd;
  int errors = 0, comparisons = 0, ticks = 0, n, d, q;
  watch_interval_timer i_watch_interval_timer (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .sub_clk_i, .stop_mode_i, .irq_ack_i, .irq_req_o,
    .irq_o, .display_clk_o, .upper_count_o);
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if ((ticks % 4) == 3)
      sub_clk_i <= ~sub_clk_i;
    if (ticks == 80000)
    begin
      errors++;
      finish_test;
    end
  end
  task finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task chkn(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    do @(posedge clk_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    rd = wb_dat_o[7:0];
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task per;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (irq_req_o !== 1'b1);
  endtask
  task watch(input int c);
    d = 0;
    q = 0;
    repeat (c)
    begin
      @(posedge clk_i);
      d += int'(display_clk_o === 1'b1);
      q += int'(irq_req_o === 1'b1);
    end
  endtask
  task half;
    n = 0;
    while (display_clk_o === 1'b1) @(posedge clk_i);
    while (display_clk_o !== 1'b1) @(posedge clk_i);
    while (display_clk_o === 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, CONTROL_RESET);
    bus(1'b0, ADDR_COUNT_INTERVAL, 8'h00);
    chk(rd, 8'h00);
    bus(1'b0, 10'h004, 8'h00);
    chk({7'h0, e}, 8'h01);
    bus(1'b1, ADDR_CONTROL, 8'hFF);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, 8'h8F);
    bus(1'b1, ADDR_CONTROL, 8'h83);
    per;
    per;
    chkn(n, 128 * DIV_64);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, 8'h93);
    bus(1'b1, ADDR_CONTROL, 8'h83);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, 8'h83);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(rd, 8'h01);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk(rd, 8'h00);
    bus(1'b1, ADDR_IRQ_MASK, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    per;
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    bus(1'b0, ADDR_CONTROL, 8'h00);
    chk(rd, 8'h83);
    watch(4096);
    chkn(int'(d > 0), 1);
    while (display_clk_o === 1'b1) @(posedge clk_i);
    while (display_clk_o !== 1'b1) @(posedge clk_i);
    bus(1'b1, ADDR_COUNT_INTERVAL, 8'hFF);
    watch(512);
    chkn(d, 0);
    bus(1'b1, ADDR_CONTROL, 8'h82);
    half;
    chkn(n, (1 << DISPLAY_TAP) * DIV_128);
    bus(1'b1, ADDR_CONTROL, 8'h81);
    half;
    chkn(n, (1 << DISPLAY_TAP) * DIV_256);
    bus(1'b1, ADDR_CONTROL, 8'h03);
    watch(9000);
    chkn(d + q, 0);
    bus(1'b0, ADDR_COUNT_INTERVAL, 8'h00);
    chk(rd, 8'h00);
    chk({1'b0, upper_count_o}, 8'h00);
    stop_mode_i <= 1'b1;
    bus(1'b1, ADDR_CONTROL, 8'h80);
    per;
    per;
    chkn(n, 128 * 8);
    finish_test;
  end
endmodule
`default_nettype wire
